// file: hw/dfda_regs.vh
`ifndef DFDA_REGS_VH
`define DFDA_REGS_VH

// Register byte offsets, decoded on haddr[15:2]
`define DFDA_OFF_GEN_CFG      16'h8300
`define DFDA_OFF_OUT_CFG      16'h8304
`define DFDA_OFF_DFIFO_DATA   16'h8378
`define DFDA_OFF_CFIFO_DATA   16'h837c
`define DFDA_OFF_STATUS       16'h8380

// display_general_config fields
`define DFDA_GEN_DIAGNOSTIC_ENABLE_BIT     0
`define DFDA_GEN_LOAD_EN_BIT  1
`define DFDA_GEN_CFG_RESET    2'h0

// display_output_config fields
`define DFDA_OUT_DIAGNOSTIC_ENABLE_BIT     0
`define DFDA_OUT_COMPRESSED_FIFO_RW_SELECT_BIT     1
`define DFDA_OUT_CFG_RESET    2'h0

// Status register fields
`define DFDA_STAT_DCNT_POS    0
`define DFDA_STAT_CCNT_POS    8
`define DFDA_STAT_WHALF_BIT   16
`define DFDA_STAT_RHALF_BIT   17

// FIFO geometry
`define DFDA_DFIFO_WIDTH      64
`define DFDA_CFIFO_WIDTH      32
`define DFDA_DFIFO_AW         3
`define DFDA_CFIFO_AW         3

`endif

// file: hw/dfda_fifo.v
`timescale 1ns/1ps
module dfda_fifo #(
  parameter WIDTH  = 32,
  parameter ADDR_W = 3
) (
  // Clock and reset
  input  wire              hclk,
  input  wire              hresetn,
  // Fill side
  input  wire              wr_en,
  input  wire [WIDTH-1:0]  wr_data,
  output wire              full,
  // Drain side
  input  wire              rd_en,
  output wire [WIDTH-1:0]  rd_data,
  output wire              empty,
  // Occupancy
  output wire [ADDR_W:0]   count
);
  localparam DEPTH = 1 << ADDR_W;

  reg  [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg  [ADDR_W:0]  wr_ptr_reg;
  reg  [ADDR_W:0]  rd_ptr_reg;
  wire             do_wr;
  wire             do_rd;

  assign full    = (wr_ptr_reg[ADDR_W] != rd_ptr_reg[ADDR_W]) &&
                   (wr_ptr_reg[ADDR_W-1:0] == rd_ptr_reg[ADDR_W-1:0]);
  assign empty   = (wr_ptr_reg == rd_ptr_reg);
  assign count   = wr_ptr_reg - rd_ptr_reg;
  assign do_wr   = wr_en & ~full;
  assign do_rd   = rd_en & ~empty;
  assign rd_data = mem_reg[rd_ptr_reg[ADDR_W-1:0]];

  // Pointer update; overflow and underflow are ignored
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_reg <= {(ADDR_W+1){1'b0}};
      rd_ptr_reg <= {(ADDR_W+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  // Entry storage, written at the write pointer
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
      always @(posedge hclk) begin
        if (do_wr && (wr_ptr_reg[ADDR_W-1:0] == i)) begin
          mem_reg[i] <= wr_data;
        end
      end
    end
  endgenerate
endmodule // dfda_fifo

// file: hw/dfda_top.v
// Functional notes
// - Every second display port write pushes one 64-bit entry.
// - A first dummy display read loads the output latch.
// - Later display reads return stored halves; every second read pops.
// - Every compressed port write with select low pushes one 32-bit entry.
// - Select high routes reads to the compressed FIFO; dummy read loads latch.
// - Later compressed reads return stored data; each read pops.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`include "dfda_regs.vh"
module dfda_top #(
  parameter DFIFO_AW = `DFDA_DFIFO_AW,
  parameter CFIFO_AW = `DFDA_CFIFO_AW
) (
  // Clock and reset
  input  wire                          hclk,
  input  wire                          hresetn,
  // AHB-Lite slave
  input  wire                          hsel,
  input  wire [31:0]                   haddr,
  input  wire [1:0]                    htrans,
  input  wire                          hwrite,
  input  wire [2:0]                    hsize,
  input  wire [31:0]                   hwdata,
  input  wire                          hready,
  output wire                          hreadyout,
  output wire                          hresp,
  output wire [31:0]                   hrdata,
  // Display pixel FIFO normal fill and drain
  input  wire                          pix_fill_valid,
  input  wire [`DFDA_DFIFO_WIDTH-1:0]  pix_fill_data,
  output wire                          pix_fill_ready,
  output wire                          pix_drain_valid,
  output wire [`DFDA_DFIFO_WIDTH-1:0]  pix_drain_data,
  input  wire                          pix_drain_ready,
  // Compressed FIFO normal fill and drain
  input  wire                          cmp_fill_valid,
  input  wire [`DFDA_CFIFO_WIDTH-1:0]  cmp_fill_data,
  output wire                          cmp_fill_ready,
  output wire                          cmp_drain_valid,
  output wire [`DFDA_CFIFO_WIDTH-1:0]  cmp_drain_data,
  input  wire                          cmp_drain_ready
);
  reg                           wr_pend_reg;
  reg                           rd_pend_reg;
  reg  [15:0]                   addr_reg;
  reg  [31:0]                   hrdata_reg;
  reg                           diagnostic_enable_en_reg;
  reg                           load_en_reg;
  reg                           out_diagnostic_enable_reg;
  reg                           compressed_fifo_rw_select_reg;
  reg  [31:0]                   low_hold_reg;
  reg                           wr_half_reg;
  reg                           rd_half_reg;
  reg  [31:0]                   disp_out_reg;
  reg  [31:0]                   cmp_out_reg;
  reg  [31:0]                   read_mux;
  wire                          addr_ok;
  wire                          disp_ok;
  wire                          cmp_ok;
  wire                          disp_wr;
  wire                          disp_rd;
  wire                          cmp_wr;
  wire                          cmp_rd;
  wire                          disp_push;
  wire                          disp_pop;
  wire                          cmp_push;
  wire                          cmp_pop;
  wire [`DFDA_DFIFO_WIDTH-1:0]  disp_wdata;
  wire [`DFDA_CFIFO_WIDTH-1:0]  cmp_wdata;
  wire [`DFDA_DFIFO_WIDTH-1:0]  disp_rdata;
  wire [`DFDA_CFIFO_WIDTH-1:0]  cmp_rdata;
  wire                          disp_full;
  wire                          disp_empty;
  wire                          cmp_full;
  wire                          cmp_empty;
  wire [DFIFO_AW:0]             disp_count;
  wire [CFIFO_AW:0]             cmp_count;

  // Bus handshake: reads take one wait state, writes none
  assign addr_ok   = hsel & hready & htrans[1];
  assign hreadyout = ~rd_pend_reg;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // Access qualifiers for the diagnostic data ports
  assign disp_ok = diagnostic_enable_en_reg & ~load_en_reg;
  assign cmp_ok  = disp_ok & out_diagnostic_enable_reg;
  assign disp_wr = wr_pend_reg & disp_ok &
                   (addr_reg == `DFDA_OFF_DFIFO_DATA);
  assign disp_rd = rd_pend_reg & disp_ok &
                   (addr_reg == `DFDA_OFF_DFIFO_DATA);
  assign cmp_wr  = wr_pend_reg & cmp_ok & ~compressed_fifo_rw_select_reg &
                   (addr_reg == `DFDA_OFF_CFIFO_DATA);
  assign cmp_rd  = rd_pend_reg & cmp_ok & compressed_fifo_rw_select_reg &
                   (addr_reg == `DFDA_OFF_CFIFO_DATA);

  // FIFO source selection between software and the display pipe
  assign disp_push  = diagnostic_enable_en_reg ? (disp_wr & wr_half_reg)
                                  : pix_fill_valid;
  assign disp_pop   = diagnostic_enable_en_reg ? (disp_rd & rd_half_reg)
                                  : pix_drain_ready;
  assign disp_wdata = diagnostic_enable_en_reg ? {hwdata, low_hold_reg} : pix_fill_data;
  assign cmp_push   = diagnostic_enable_en_reg ? cmp_wr
                                  : cmp_fill_valid;
  assign cmp_pop    = diagnostic_enable_en_reg ? cmp_rd
                                  : cmp_drain_ready;
  assign cmp_wdata  = diagnostic_enable_en_reg ? hwdata : cmp_fill_data;

  assign pix_fill_ready  = ~diagnostic_enable_en_reg & ~disp_full;
  assign pix_drain_valid = ~diagnostic_enable_en_reg & ~disp_empty;
  assign pix_drain_data  = disp_rdata;
  assign cmp_fill_ready  = ~diagnostic_enable_en_reg & ~cmp_full;
  assign cmp_drain_valid = ~diagnostic_enable_en_reg & ~cmp_empty;
  assign cmp_drain_data  = cmp_rdata;

  // Read data selection
  always @* begin
    read_mux = 32'h0;
    case (addr_reg)
      `DFDA_OFF_GEN_CFG: begin
        read_mux[`DFDA_GEN_DIAGNOSTIC_ENABLE_BIT]    = diagnostic_enable_en_reg;
        read_mux[`DFDA_GEN_LOAD_EN_BIT] = load_en_reg;
      end
      `DFDA_OFF_OUT_CFG: begin
        read_mux[`DFDA_OUT_DIAGNOSTIC_ENABLE_BIT] = out_diagnostic_enable_reg;
        read_mux[`DFDA_OUT_COMPRESSED_FIFO_RW_SELECT_BIT] = compressed_fifo_rw_select_reg;
      end
      `DFDA_OFF_DFIFO_DATA: begin
        read_mux = disp_ok ? disp_out_reg : 32'h0;
      end
      `DFDA_OFF_CFIFO_DATA: begin
        read_mux = (cmp_ok & compressed_fifo_rw_select_reg) ? cmp_out_reg : 32'h0;
      end
      `DFDA_OFF_STATUS: begin
        read_mux[`DFDA_STAT_DCNT_POS +: DFIFO_AW+1] = disp_count;
        read_mux[`DFDA_STAT_CCNT_POS +: CFIFO_AW+1] = cmp_count;
        read_mux[`DFDA_STAT_WHALF_BIT] = wr_half_reg;
        read_mux[`DFDA_STAT_RHALF_BIT] = rd_half_reg;
      end
      default: begin
        read_mux = 32'h0;
      end
    endcase
  end

  // Address phase capture and read data register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 16'h0;
      hrdata_reg  <= 32'h0;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      rd_pend_reg <= addr_ok & ~hwrite;
      if (addr_ok) begin
        addr_reg <= {haddr[15:2], 2'b00};
      end
      if (rd_pend_reg) begin
        hrdata_reg <= read_mux;
      end
    end
  end

  // Configuration registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      diagnostic_enable_en_reg  <= 1'b0;
      load_en_reg  <= 1'b0;
      out_diagnostic_enable_reg <= 1'b0;
      compressed_fifo_rw_select_reg     <= 1'b0;
    end else if (wr_pend_reg) begin
      if (addr_reg == `DFDA_OFF_GEN_CFG) begin
        diagnostic_enable_en_reg <= hwdata[`DFDA_GEN_DIAGNOSTIC_ENABLE_BIT];
        load_en_reg <= hwdata[`DFDA_GEN_LOAD_EN_BIT];
      end
      if (addr_reg == `DFDA_OFF_OUT_CFG) begin
        out_diagnostic_enable_reg <= hwdata[`DFDA_OUT_DIAGNOSTIC_ENABLE_BIT];
        compressed_fifo_rw_select_reg     <= hwdata[`DFDA_OUT_COMPRESSED_FIFO_RW_SELECT_BIT];
      end
    end
  end

  // Display port pairing of 32-bit halves into 64-bit entries
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_hold_reg <= 32'h0;
      wr_half_reg  <= 1'b0;
      rd_half_reg  <= 1'b0;
      disp_out_reg <= 32'h0;
    end else if (!disp_ok) begin
      wr_half_reg <= 1'b0;
      rd_half_reg <= 1'b0;
    end else begin
      if (disp_wr) begin
        rd_half_reg <= 1'b0;
        if (!wr_half_reg) begin
          low_hold_reg <= hwdata;
          wr_half_reg  <= 1'b1;
        end else begin
          wr_half_reg <= 1'b0;
        end
      end
      if (disp_rd) begin
        if (!rd_half_reg) begin
          disp_out_reg <= disp_rdata[31:0];
          rd_half_reg  <= 1'b1;
        end else begin
          disp_out_reg <= disp_rdata[63:32];
          rd_half_reg  <= 1'b0;
        end
      end
    end
  end

  // Compressed port output latch
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_out_reg <= 32'h0;
    end else if (cmp_rd) begin
      cmp_out_reg <= cmp_rdata;
    end
  end

  dfda_fifo #(
    .WIDTH   (`DFDA_DFIFO_WIDTH),
    .ADDR_W  (DFIFO_AW)
  ) u_disp_fifo (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (disp_push),
    .wr_data (disp_wdata),
    .full    (disp_full),
    .rd_en   (disp_pop),
    .rd_data (disp_rdata),
    .empty   (disp_empty),
    .count   (disp_count)
  );

  dfda_fifo #(
    .WIDTH   (`DFDA_CFIFO_WIDTH),
    .ADDR_W  (CFIFO_AW)
  ) u_cmp_fifo (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (cmp_push),
    .wr_data (cmp_wdata),
    .full    (cmp_full),
    .rd_en   (cmp_pop),
    .rd_data (cmp_rdata),
    .empty   (cmp_empty),
    .count   (cmp_count)
  );
endmodule // dfda_top

// file: bench/dfda_top_sva.sv
`timescale 1ns/1ps
`include "dfda_regs.vh"
module dfda_top_sva #(
  parameter DFIFO_AW = 3,
  parameter CFIFO_AW = 3
) (
  // Clock and reset
  input wire        hclk,
  input wire        hresetn,
  // Bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  // Streams
  input wire        pix_fill_valid,
  input wire        pix_fill_ready,
  input wire        pix_drain_valid,
  input wire        cmp_fill_valid,
  input wire        cmp_fill_ready,
  input wire        cmp_drain_valid
);
  wire  rd_take;
  wire  wr_take;
  logic gen_wr_reg;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;
  // Data phase of a general config write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      gen_wr_reg <= 1'b0;
    else
      gen_wr_reg <= wr_take && (haddr[15:0] == `DFDA_OFF_GEN_CFG);
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay)
    else $error("response not okay");
  property p_rd_wait; rd_take |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read data phase not one wait state");
  property p_wr_nowait; wr_take |=> hreadyout; endproperty
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write data phase stalled");
  property p_low_cause; !hreadyout |-> $past(rd_take); endproperty
  a_low_cause: assert property (p_low_cause)
    else $error("wait state without read");
  property p_rdata_hold; !$stable(hrdata) |-> $past(!hreadyout); endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed outside read");
  property p_diagnostic_enable_stop;
    gen_wr_reg && hwdata[0] |=> !pix_fill_ready && !cmp_fill_ready &&
      !pix_drain_valid && !cmp_drain_valid;
  endproperty
  a_diagnostic_enable_stop: assert property (p_diagnostic_enable_stop)
    else $error("normal streams active in diagnostic mode");
  property p_pix_push;
    pix_fill_valid && pix_fill_ready && !gen_wr_reg |=> pix_drain_valid;
  endproperty
  a_pix_push: assert property (p_pix_push)
    else $error("pixel push not visible");
  property p_cmp_push;
    cmp_fill_valid && cmp_fill_ready && !gen_wr_reg |=> cmp_drain_valid;
  endproperty
  a_cmp_push: assert property (p_cmp_push)
    else $error("compressed push not visible");
  c_rd: cover property (rd_take);
  c_diagnostic_enable: cover property (gen_wr_reg && hwdata[0]);
  c_push: cover property (pix_fill_valid && pix_fill_ready);
endmodule // dfda_top_sva
bind dfda_top dfda_top_sva #(.DFIFO_AW(DFIFO_AW), .CFIFO_AW(CFIFO_AW)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .pix_fill_valid(pix_fill_valid), .pix_fill_ready(pix_fill_ready),
  .pix_drain_valid(pix_drain_valid), .cmp_fill_valid(cmp_fill_valid),
  .cmp_fill_ready(cmp_fill_ready), .cmp_drain_valid(cmp_drain_valid));

// file: bench/tb_top.sv
`timescale 1ns/1ps
`include "dfda_regs.vh"
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, pfv, pdr, cfv, cdr;
  logic [31:0] haddr, hwdata, tmp, cfd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [63:0] pfd;
  wire         hreadyout, hresp, pfr, pdv, cfr, cdv;
  wire  [31:0] hrdata, cdd;
  wire  [63:0] pdd;
  int          n_fail, checks_done;
  dfda_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pix_fill_valid(pfv), .pix_fill_data(pfd),
    .pix_fill_ready(pfr), .pix_drain_valid(pdv), .pix_drain_data(pdd),
    .pix_drain_ready(pdr), .cmp_fill_valid(cfv), .cmp_fill_data(cfd),
    .cmp_fill_ready(cfr), .cmp_drain_valid(cdv), .cmp_drain_data(cdd),
    .cmp_drain_ready(cdr));
  task final_report;
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Hold the phase until hready is seen high at a rising edge
  task wait_rdy;
    logic rdy;
    rdy = 1'b0;
    for (int k = 0; k < 20 && !rdy; k++) begin
      @(negedge hclk);
      rdy = hreadyout;
      tmp = hrdata;
      @(posedge hclk);
    end
    if (!rdy) begin
      n_fail++;
      final_report;
    end
  endtask
  task ahb(input logic w, input logic [15:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {16'h0000, a};
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask
  task rd(input logic [15:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check({32'h0, tmp}, {32'h0, e});
  endtask
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    {hsel, hwrite, pfv, pdr, cfv, cdr, htrans} = '0;
    {haddr, hwdata, cfd, pfd, tmp} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`DFDA_OFF_GEN_CFG, 32'h0);
    rd(`DFDA_OFF_STATUS, 32'h0);
    rd(16'h8310, 32'h0);
    pfd <= 64'h0123_4567_89ab_cdef;
    cfd <= 32'h5a5a_0f0f;
    {pfv, cfv} <= 2'b11;
    @(posedge hclk);
    {pfv, cfv} <= 2'b00;
    @(negedge hclk);
    check({pdv, cdv, cdd}, {2'b11, 32'h5a5a_0f0f});
    check(pdd, 64'h0123_4567_89ab_cdef);
    @(posedge hclk);
    ahb(1'b1, `DFDA_OFF_GEN_CFG, 32'h1);
    {pdr, cdr} <= 2'b11;
    @(negedge hclk);
    check({pfr, pdv, cfr, cdv}, 4'h0);
    repeat (3) @(posedge hclk);
    rd(`DFDA_OFF_STATUS, 32'h101);
    ahb(1'b1, `DFDA_OFF_GEN_CFG, 32'h0);
    ahb(1'b1, `DFDA_OFF_DFIFO_DATA, 32'hdead_beef);
    rd(`DFDA_OFF_STATUS, 32'h0);
    {pdr, cdr} <= 2'b00;
    ahb(1'b1, `DFDA_OFF_GEN_CFG, 32'h1);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, `DFDA_OFF_DFIFO_DATA, 32'ha5a5_0000 | i);
      rd(`DFDA_OFF_STATUS,
         (i[0] ? 32'h0 : 32'h10000) | (i + 1) / 2);
    end
    ahb(1'b0, `DFDA_OFF_DFIFO_DATA, 32'h0);
    for (int i = 0; i < 4; i++)
      rd(`DFDA_OFF_DFIFO_DATA, 32'ha5a5_0000 | i);
    // Fourth read leaves the low-half latch state pending
    rd(`DFDA_OFF_STATUS, 32'h20000);
    ahb(1'b1, `DFDA_OFF_OUT_CFG, 32'h1);
    for (int i = 0; i < 3; i++)
      ahb(1'b1, `DFDA_OFF_CFIFO_DATA, 32'hc3c3_0000 | i);
    rd(`DFDA_OFF_CFIFO_DATA, 32'h0);
    rd(`DFDA_OFF_STATUS, 32'h20300);
    ahb(1'b1, `DFDA_OFF_OUT_CFG, 32'h3);
    ahb(1'b0, `DFDA_OFF_CFIFO_DATA, 32'h0);
    for (int i = 0; i < 3; i++)
      rd(`DFDA_OFF_CFIFO_DATA, 32'hc3c3_0000 | i);
    rd(`DFDA_OFF_STATUS, 32'h20000);
    final_report;
  end
endmodule // tb_top
